// ---- core/sscs_strength_cs.sv ----
// Purpose: Signal strength readout, carrier sense and power-up ready signalling
// Assumes: Chip select and strobes arrive asynchronously; gain/level from same clock
// Notes:   Strength is signed half-dB units
`timescale 1ns/1ns
// Function
// RQ1 - Strength comes from present gain setting plus measured channel level.
// RQ2 - With sync detection, strength updates until sync found, then holds until next receive.
// RQ3 - Strength is two's complement dBm in half-dB steps.
// RQ4 - Update rate is twice bandwidth over eight times two to filter length.
// RQ5 - Appended status byte carries the packet's final strength value.
// RQ6 - Host converts raw readings, subtracting 256, halving, minus offset 74.
// RQ7 - Absolute carrier sense asserts above threshold, deasserts below, with hysteresis.
// RQ8 - Relative carrier sense follows step rises and falls of programmed size.
// RQ9 - Absolute offset field shifts threshold by plus or minus seven dB.
// RQ10 - Relative field disables or selects 6, 10 or 14 dB steps.
// RQ11 - Carrier-sense qualifier allows sync search only above threshold.
// RQ12 - Carrier sense visible on output pin with code 14 and status bit.
// RQ13 - Host lowers front amp ceiling first, then digital ceiling, for strong signals.
// RQ14 - State changes on host strobes or internal events like overflow.
// RQ15 - After reset, output pin zero drives clock divided by 192.
// RQ16 - Host should reprogram output pin zero after reset.
// RQ17 - Ready flag driven on data-out once chip select asserted.
// RQ18 - After reset completes, device idles with oscillator running.
// RQ19 - With stable oscillator, data-out low immediately after chip select low.
// RQ20 - Chip select before ready shows high on data-out, then low.
// RQ21 - Current state number readable as a status value.
// RQ22 - Top bit of sync qualifier mode adds carrier-sense requirement.
// RQ23 - Both conditions re-evaluated per new sample and combined into one output.
module sscs_strength_cs (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      chipSelectLow,
  input  wire logic                      strobeRx,
  input  wire logic                      strobeIdle,
  input  wire logic                      rxOverflow,
  input  wire logic                      syncDetect,
  input  wire logic                      packetEnd,
  input  wire logic [7:0]                rxGainDb,
  input  wire logic [7:0]                channelLevel,
  input  wire sscs_pkg::sscs_gain_cfg_s  gainCfg,
  input  wire logic [3:0]                csAbsoluteOffset,
  input  wire logic [1:0]                csRelativeStepSel,
  input  wire logic [7:0]                csBaseThreshold,
  input  wire logic [1:0]                filterLength,
  input  wire logic [2:0]                syncMode,
  input  wire logic                      appendPacketStatusEn,
  input  wire logic [4:0]                generalOutSelect,
  input  wire logic                      generalOutSelectWr,
  output logic [7:0]                     strengthValue,
  output logic                           carrierSense,
  output logic                           syncSearchEn,
  output logic [7:0]                     statusByte,
  output logic                           statusByteValid,
  output logic                           generalOutPin0,
  output logic                           serialDataOut,
  output logic                           serialDataOutEnLow,
  output logic [4:0]                     radioStateNumber,
  output sscs_pkg::sscs_pkt_status_s     packetStatusReg
);
  sscs_pkg::sscs_state_e stateQ;
  logic [1:0] csnSyncQ, rxSyncQ, idleSyncQ;
  logic       rxPrevQ, idlePrevQ;
  logic [8:0] sampleCntQ;
  logic       sampleTick;
  logic [7:0] rawStrength;
  logic [7:0] prevStrengthQ;
  logic       frozenQ;
  logic       absCsQ, relCsQ;
  logic [6:0] divCntQ;
  logic       divClkQ;
  logic [4:0] gdoSelQ;
  logic [7:0] pupCntQ;
  logic       rxRise, idleRise;
  logic [7:0] csThr, csThrLow, csStep, relUpLim, relDnLim;

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7]) sat_add = s[8] ? 8'h80 : 8'h7f;
    else sat_add = s[7:0];
  endfunction

  function automatic logic [7:0] rel_step(input logic [1:0] sel);
    unique case (sel)
      2'h1:    rel_step = 8'h0c;
      2'h2:    rel_step = 8'h14;
      2'h3:    rel_step = 8'h1c;
      default: rel_step = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk) begin
    csnSyncQ  <= reset ? 2'h3 : {csnSyncQ[0], chipSelectLow};
    rxSyncQ   <= reset ? 2'h0 : {rxSyncQ[0], strobeRx};
    idleSyncQ <= reset ? 2'h0 : {idleSyncQ[0], strobeIdle};
    rxPrevQ   <= reset ? 1'b0 : rxSyncQ[1];
    idlePrevQ <= reset ? 1'b0 : idleSyncQ[1];
  end
  assign rxRise   = rxSyncQ[1] & ~rxPrevQ;
  assign idleRise = idleSyncQ[1] & ~idlePrevQ;

  // Power-up sequence then state changes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stateQ  <= sscs_pkg::SSCS_PWRUP;
      pupCntQ <= 8'h00;
    end else begin
      unique case (stateQ)
        sscs_pkg::SSCS_PWRUP: begin
          pupCntQ <= pupCntQ + 8'h01;
          if (pupCntQ == 8'(sscs_pkg::POWERUP_CYCLES - 1)) stateQ <= sscs_pkg::SSCS_IDLE; // RQ18
        end
        sscs_pkg::SSCS_IDLE: if (rxRise) stateQ <= sscs_pkg::SSCS_RX; // RQ14
        sscs_pkg::SSCS_RX: begin
          if (idleRise) stateQ <= sscs_pkg::SSCS_IDLE; // RQ14
          else if (rxOverflow) stateQ <= sscs_pkg::SSCS_OVF; // RQ14
        end
        sscs_pkg::SSCS_OVF: if (idleRise) stateQ <= sscs_pkg::SSCS_IDLE; // RQ14
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) radioStateNumber <= 5'h00;
    else begin
      unique case (stateQ)
        sscs_pkg::SSCS_PWRUP: radioStateNumber <= 5'h00;
        sscs_pkg::SSCS_IDLE:  radioStateNumber <= sscs_pkg::STATE_NUM_IDLE; // RQ21
        sscs_pkg::SSCS_RX:    radioStateNumber <= sscs_pkg::STATE_NUM_RX; // RQ21
        sscs_pkg::SSCS_OVF:   radioStateNumber <= sscs_pkg::STATE_NUM_OVF; // RQ21
      endcase
    end
  end

  // Sample period 4 * 2^filterLength cycles
  always_ff @(posedge core_clk) begin
    if (reset || stateQ != sscs_pkg::SSCS_RX) sampleCntQ <= 9'h000;
    else if (sampleTick) sampleCntQ <= 9'h000;
    else sampleCntQ <= sampleCntQ + 9'h001;
  end
  assign sampleTick = (stateQ == sscs_pkg::SSCS_RX) &&
                      (sampleCntQ >= 9'((sscs_pkg::FILT_BASE_CYCLES << filterLength) - 1)); // RQ4

  assign rawStrength = sat_add(channelLevel, rxGainDb); // RQ1 RQ3

  // Strength value with freeze on sync
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strengthValue <= sscs_pkg::RESET_STRENGTH;
      prevStrengthQ <= sscs_pkg::RESET_STRENGTH;
      frozenQ       <= 1'b0;
    end else begin
      if (stateQ == sscs_pkg::SSCS_IDLE && rxRise) frozenQ <= 1'b0; // RQ2
      else if (stateQ == sscs_pkg::SSCS_RX && syncDetect && syncMode[1:0] != 2'h0) frozenQ <= 1'b1; // RQ2
      if (sampleTick) begin
        prevStrengthQ <= rawStrength;
        if (!frozenQ) strengthValue <= rawStrength; // RQ2
      end
    end
  end

  // Carrier sense per sample
  assign csThr    = sat_add(csBaseThreshold, {{3{csAbsoluteOffset[3]}}, csAbsoluteOffset, 1'b0}); // RQ9
  assign csThrLow = sat_add(csThr, 8'hfe); // RQ7
  assign csStep   = rel_step(csRelativeStepSel); // RQ10
  assign relUpLim = sat_add(prevStrengthQ, csStep); // RQ8
  assign relDnLim = sat_add(prevStrengthQ, 8'(-csStep)); // RQ8
  always_ff @(posedge core_clk) begin
    if (reset || stateQ != sscs_pkg::SSCS_RX) begin
      absCsQ <= 1'b0;
      relCsQ <= 1'b0;
    end else if (sampleTick) begin
      if ($signed(rawStrength) > $signed(csThr)) absCsQ <= 1'b1; // RQ7 RQ23
      else if ($signed(rawStrength) < $signed(csThrLow)) absCsQ <= 1'b0; // RQ7
      if (csRelativeStepSel == 2'h0) relCsQ <= 1'b0; // RQ10
      else if ($signed(rawStrength) >= $signed(relUpLim)) relCsQ <= 1'b1; // RQ8 RQ23
      else if ($signed(rawStrength) <= $signed(relDnLim)) relCsQ <= 1'b0; // RQ8
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      carrierSense    <= 1'b0;
      syncSearchEn    <= 1'b0;
      packetStatusReg <= '0;
    end else begin
      carrierSense <= absCsQ | relCsQ; // RQ23
      syncSearchEn <= (stateQ == sscs_pkg::SSCS_RX) &&
                      (!syncMode[sscs_pkg::SYNCQ_CS_BIT] || absCsQ | relCsQ); // RQ11 RQ22
      packetStatusReg.csAbove   <= absCsQ | relCsQ; // RQ12
      packetStatusReg.syncFound <= frozenQ;
      packetStatusReg.reserved  <= 6'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      statusByte      <= 8'h00;
      statusByteValid <= 1'b0;
    end else begin
      statusByteValid <= packetEnd & appendPacketStatusEn; // RQ5
      if (packetEnd & appendPacketStatusEn) statusByte <= strengthValue; // RQ5
    end
  end

  // Output pin zero selection and divided clock
  always_ff @(posedge core_clk) begin
    if (reset) gdoSelQ <= sscs_pkg::RESET_GDO_SEL; // RQ15
    else if (generalOutSelectWr) gdoSelQ <= generalOutSelect;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      divCntQ <= 7'h00;
      divClkQ <= 1'b0;
    end else if (divCntQ == 7'(sscs_pkg::GDO_HALF_DIV - 1)) begin
      divCntQ <= 7'h00;
      divClkQ <= ~divClkQ; // RQ15
    end else divCntQ <= divCntQ + 7'h01;
  end

  always_ff @(posedge core_clk) begin
    if (reset) generalOutPin0 <= 1'b0;
    else begin
      unique case (gdoSelQ)
        sscs_pkg::SEL_CARRIER_SENSE: generalOutPin0 <= absCsQ | relCsQ; // RQ12
        sscs_pkg::SEL_CLK_DIV:       generalOutPin0 <= ~divClkQ; // RQ15
        sscs_pkg::SEL_SYNC_FOUND:    generalOutPin0 <= frozenQ;
        default:                     generalOutPin0 <= 1'b0;
      endcase
    end
  end

  // Ready indication on serial data-out
  always_ff @(posedge core_clk) begin
    if (reset) begin
      serialDataOut      <= 1'b1;
      serialDataOutEnLow <= 1'b1;
    end else begin
      serialDataOutEnLow <= csnSyncQ[1]; // RQ17
      serialDataOut      <= (stateQ == sscs_pkg::SSCS_PWRUP); // RQ19 RQ20
    end
  end

  a_div_toggle: assert property (@(posedge core_clk) disable iff (reset) // RQ15
    (divCntQ == 7'(sscs_pkg::GDO_HALF_DIV - 1)) |=> (divClkQ != $past(divClkQ)))
    else $error("Divider did not toggle");
  a_ready_low: assert property (@(posedge core_clk) disable iff (reset) // RQ19
    (stateQ == sscs_pkg::SSCS_IDLE) |=> !serialDataOut)
    else $error("Data-out not low when ready");
  a_ready_high: assert property (@(posedge core_clk) disable iff (reset) // RQ20
    (stateQ == sscs_pkg::SSCS_PWRUP) |=> serialDataOut)
    else $error("Data-out not high during power-up");
  a_drive_cs: assert property (@(posedge core_clk) disable iff (reset) // RQ17
    !csnSyncQ[1] |=> !serialDataOutEnLow)
    else $error("Data-out not driven with chip select");
  a_strength_hold: assert property (@(posedge core_clk) disable iff (reset) // RQ2
    (frozenQ && $past(frozenQ)) |-> $stable(strengthValue))
    else $error("Strength changed while frozen");
  a_append_value: assert property (@(posedge core_clk) disable iff (reset) // RQ5
    (packetEnd && appendPacketStatusEn) |=> statusByteValid && statusByte == $past(strengthValue))
    else $error("Appended byte wrong");
  a_cs_combine: assert property (@(posedge core_clk) disable iff (reset) // RQ23
    ##1 carrierSense == ($past(absCsQ) | $past(relCsQ)))
    else $error("Carrier sense not combined");
  a_rel_off: assert property (@(posedge core_clk) disable iff (reset) // RQ10
    (csRelativeStepSel == 2'h0 && sampleTick) |=> !relCsQ)
    else $error("Relative sense active while disabled");
  a_sync_gate: assert property (@(posedge core_clk) disable iff (reset) // RQ11
    (syncMode[2] && !absCsQ && !relCsQ) |=> !syncSearchEn)
    else $error("Sync search without carrier");
  a_state_num: assert property (@(posedge core_clk) disable iff (reset) // RQ21
    (stateQ == sscs_pkg::SSCS_RX) |=> radioStateNumber == sscs_pkg::STATE_NUM_RX)
    else $error("State number mismatch");
  a_abs_set: assert property (@(posedge core_clk) disable iff (reset) // RQ7
    (sampleTick && $signed(rawStrength) > $signed(csThr)) |=> absCsQ)
    else $error("Absolute sense not set above threshold");
  a_abs_clear: assert property (@(posedge core_clk) disable iff (reset) // RQ7
    (sampleTick && $signed(rawStrength) < $signed(csThrLow)) |=> !absCsQ)
    else $error("Absolute sense not cleared below threshold");
  a_rel_set: assert property (@(posedge core_clk) disable iff (reset) // RQ8
    (sampleTick && csRelativeStepSel != 2'h0 && $signed(rawStrength) >= $signed(relUpLim)) |=> relCsQ)
    else $error("Relative sense not set on rise");
  a_rel_clear: assert property (@(posedge core_clk) disable iff (reset) // RQ8
    (sampleTick && csRelativeStepSel != 2'h0 && $signed(rawStrength) < $signed(relUpLim) &&
     $signed(rawStrength) <= $signed(relDnLim)) |=> !relCsQ)
    else $error("Relative sense not cleared on fall");
  a_tick_gap: assert property (@(posedge core_clk) disable iff (reset) // RQ4
    sampleTick |=> !sampleTick)
    else $error("Samples too close together");
  a_rx_entry: assert property (@(posedge core_clk) disable iff (reset) // RQ14
    (stateQ == sscs_pkg::SSCS_IDLE && rxRise) |=> stateQ == sscs_pkg::SSCS_RX)
    else $error("Receive strobe not taken");
  a_ovf_entry: assert property (@(posedge core_clk) disable iff (reset) // RQ14
    (stateQ == sscs_pkg::SSCS_RX && !idleRise && rxOverflow) |=> stateQ == sscs_pkg::SSCS_OVF)
    else $error("Overflow not taken");
  a_pwrup_done: assert property (@(posedge core_clk) disable iff (reset) // RQ18
    (stateQ == sscs_pkg::SSCS_PWRUP && pupCntQ == 8'(sscs_pkg::POWERUP_CYCLES - 1)) |=>
    stateQ == sscs_pkg::SSCS_IDLE)
    else $error("Power-up did not end in idle");
  a_freeze_clear: assert property (@(posedge core_clk) disable iff (reset) // RQ2
    (stateQ == sscs_pkg::SSCS_IDLE && rxRise) |=> !frozenQ)
    else $error("Freeze kept on receive entry");
  a_append_off: assert property (@(posedge core_clk) disable iff (reset) // RQ5
    (packetEnd && !appendPacketStatusEn) |=> !statusByteValid)
    else $error("Status byte appended while disabled");
endmodule

// ---- core/sscs_pkg.sv ----
// Purpose: Shared constants and carriers for the strength and carrier-sense block
// Assumes: 20 MHz core clock
// Notes:   State numbers and power-up length are plain defaults
package sscs_pkg;
  localparam int unsigned CORE_CLK_HZ       = 20000000;
  localparam int unsigned GDO_CLK_DIV       = 192;
  localparam int unsigned GDO_HALF_DIV      = GDO_CLK_DIV / 2;
  localparam int unsigned FILT_BASE_CYCLES  = 4;
  localparam int unsigned POWERUP_CYCLES    = 64;
  localparam logic [4:0]  SEL_CARRIER_SENSE = 5'h0e;
  localparam logic [4:0]  SEL_CLK_DIV       = 5'h1e;
  localparam logic [4:0]  SEL_SYNC_FOUND    = 5'h06;
  localparam logic [4:0]  RESET_GDO_SEL     = 5'h1e;
  localparam int unsigned SYNCQ_CS_BIT      = 2;
  localparam logic [7:0]  RESET_STRENGTH    = 8'h80;
  localparam logic [4:0]  STATE_NUM_IDLE    = 5'h01;
  localparam logic [4:0]  STATE_NUM_RX      = 5'h0d;
  localparam logic [4:0]  STATE_NUM_OVF     = 5'h11;

  typedef enum logic [1:0] {
    SSCS_PWRUP,
    SSCS_IDLE,
    SSCS_RX,
    SSCS_OVF
  } sscs_state_e;

  typedef struct packed {
    logic       csAbove;
    logic       syncFound;
    logic [5:0] reserved;
  } sscs_pkt_status_s;

  typedef struct packed {
    logic [2:0] frontAmpGainCeiling;
    logic [1:0] digitalGainCeiling;
    logic [2:0] demodLevelTarget;
  } sscs_gain_cfg_s;
endpackage

// ---- tb/sscs_host_model.sv ----
// Purpose: Host controller model driving select, strobes and pin selection
// Assumes: Signals change only on the rising clock edge
// Notes:   Strobes are held for several cycles to pass the synchroniser
`timescale 1ns/1ns
module sscs_host_model (
  input  wire logic core_clk,
  output logic       chipSelectLow,
  output logic       strobeRx,
  output logic       strobeIdle,
  output logic [4:0] generalOutSelect,
  output logic       generalOutSelectWr
);
  initial begin
    chipSelectLow      = 1'b1;
    strobeRx           = 1'b0;
    strobeIdle         = 1'b0;
    generalOutSelect   = 5'h15;
    generalOutSelectWr = 1'b0;
  end
  task automatic select(input logic lvl);
    @(posedge core_clk) chipSelectLow <= lvl;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic command(input logic toRx);
    @(posedge core_clk);
    if (toRx) strobeRx <= 1'b1;
    else strobeIdle <= 1'b1;
    repeat (4) @(posedge core_clk);
    strobeRx   <= 1'b0;
    strobeIdle <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic set_gdo(input logic [4:0] code);
    @(posedge core_clk);
    generalOutSelect   <= code;
    generalOutSelectWr <= 1'b1;
    @(posedge core_clk);
    generalOutSelect   <= ~code;
    generalOutSelectWr <= 1'b0;
  endtask
  // Raw reading to half-dB absolute power with typical offset
  function automatic int raw_to_half_dbm(input logic [7:0] raw);
    return (raw >= 8'h80 ? int'(raw) - 256 : int'(raw)) - 148;
  endfunction
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for strength readout and carrier sense
// Assumes: Sample period 4 cycles with filter length 0
// Notes:   Gain ceilings set to all ones, then changed once before the second receive entry
`timescale 1ns/1ns
module tb_top;
  logic core_clk, reset, rxOverflow, syncDetect, packetEnd, appendPacketStatusEn;
  logic [7:0] rxGainDb, channelLevel, csBaseThreshold;
  logic [3:0] csAbsoluteOffset;
  logic [1:0] csRelativeStepSel, filterLength;
  logic [2:0] syncMode;
  logic chipSelectLow, strobeRx, strobeIdle, generalOutSelectWr;
  logic [4:0] generalOutSelect, radioStateNumber;
  logic [7:0] strengthValue, statusByte;
  logic carrierSense, syncSearchEn, statusByteValid, generalOutPin0, serialDataOut, serialDataOutEnLow;
  sscs_pkg::sscs_pkt_status_s packetStatusReg;
  sscs_pkg::sscs_gain_cfg_s   gainCfg;
  int n_fail = 0;
  int checked = 0;
  sscs_host_model hostU (.core_clk(core_clk), .chipSelectLow(chipSelectLow), .strobeRx(strobeRx),
    .strobeIdle(strobeIdle), .generalOutSelect(generalOutSelect), .generalOutSelectWr(generalOutSelectWr));
  sscs_strength_cs dut_u (.core_clk(core_clk), .reset(reset), .chipSelectLow(chipSelectLow),
    .strobeRx(strobeRx), .strobeIdle(strobeIdle), .rxOverflow(rxOverflow), .syncDetect(syncDetect),
    .packetEnd(packetEnd), .rxGainDb(rxGainDb), .channelLevel(channelLevel), .gainCfg(gainCfg),
    .csAbsoluteOffset(csAbsoluteOffset), .csRelativeStepSel(csRelativeStepSel),
    .csBaseThreshold(csBaseThreshold), .filterLength(filterLength), .syncMode(syncMode),
    .appendPacketStatusEn(appendPacketStatusEn), .generalOutSelect(generalOutSelect),
    .generalOutSelectWr(generalOutSelectWr), .strengthValue(strengthValue), .carrierSense(carrierSense),
    .syncSearchEn(syncSearchEn), .statusByte(statusByte), .statusByteValid(statusByteValid),
    .generalOutPin0(generalOutPin0), .serialDataOut(serialDataOut), .serialDataOutEnLow(serialDataOutEnLow),
    .radioStateNumber(radioStateNumber), .packetStatusReg(packetStatusReg));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_state(input logic [4:0] s);
    int i;
    i = 0;
    while (radioStateNumber !== s && i < 100) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk({3'h0, radioStateNumber}, {3'h0, s});
  endtask
  task automatic put(input logic [7:0] g, input logic [7:0] l);
    @(posedge core_clk);
    rxGainDb     <= g;
    channelLevel <= l;
    repeat (12) @(posedge core_clk);
    #1;
  endtask
  task automatic chk_cs(input logic e);
    chk({7'h0, carrierSense}, {7'h0, e});
    chk({7'h0, generalOutPin0}, {7'h0, e});
    chk({7'h0, packetStatusReg.csAbove}, {7'h0, e});
  endtask
  task automatic period_chk(input int fl);
    int c, t1, n;
    logic [7:0] prev;
    c = 0; n = 0; t1 = 0; prev = strengthValue;
    @(posedge core_clk) filterLength <= fl[1:0];
    while (n < 3 && c < 300) begin
      @(posedge core_clk) channelLevel <= channelLevel + 8'h01;
      #1;
      c++;
      if (strengthValue !== prev) begin
        n++;
        if (n == 2) t1 = c;
        if (n == 3) chk(8'(c - t1), 8'(4 << fl));
      end
      prev = strengthValue;
    end
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end
  initial begin
    int c, st;
    reset = 1'b1; rxOverflow = 1'b0; syncDetect = 1'b0; packetEnd = 1'b0; appendPacketStatusEn = 1'b1;
    rxGainDb = 8'h00; channelLevel = 8'h00; csBaseThreshold = 8'h10; csAbsoluteOffset = 4'h0;
    csRelativeStepSel = 2'h0; filterLength = 2'h0; syncMode = 3'h0;
    gainCfg = '1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    hostU.select(1'b0);
    #1;
    chk(strengthValue, sscs_pkg::RESET_STRENGTH);
    chk({7'h0, serialDataOut}, 8'h01);
    chk({7'h0, serialDataOutEnLow}, 8'h00);
    wait_state(sscs_pkg::STATE_NUM_IDLE);
    @(posedge core_clk) #1 chk({7'h0, serialDataOut}, 8'h00);
    hostU.select(1'b1);
    hostU.select(1'b0);
    #1 chk({7'h0, serialDataOut}, 8'h00);
    c = 0;
    while (generalOutPin0 !== 1'b0 && c < 400) begin @(posedge core_clk); #1; c++; end
    while (generalOutPin0 !== 1'b1 && c < 400) begin @(posedge core_clk); #1; c++; end
    st = c;
    while (generalOutPin0 !== 1'b0 && c < 800) begin @(posedge core_clk); #1; c++; end
    while (generalOutPin0 !== 1'b1 && c < 800) begin @(posedge core_clk); #1; c++; end
    chk(8'(c - st), 8'(sscs_pkg::GDO_CLK_DIV));
    hostU.set_gdo(sscs_pkg::SEL_CARRIER_SENSE);
    hostU.command(1'b1);
    wait_state(sscs_pkg::STATE_NUM_RX);
    put(8'h10, 8'hf0); chk(strengthValue, 8'h00);
    put(8'hc0, 8'h10); chk(strengthValue, 8'hd0);
    chk(8'(hostU.raw_to_half_dbm(strengthValue)), 8'h3c);
    put(8'h70, 8'h70); chk(strengthValue, 8'h7f);
    rxGainDb <= 8'h00;
    for (int f = 0; f < 4; f++) period_chk(f);
    @(posedge core_clk) filterLength <= 2'h0;
    put(8'h00, 8'h20); chk_cs(1'b1);
    put(8'h00, 8'h0f); chk_cs(1'b1);
    put(8'h00, 8'h0c); chk_cs(1'b0);
    csAbsoluteOffset <= 4'h7;
    put(8'h00, 8'h1c); chk_cs(1'b0);
    put(8'h00, 8'h20); chk_cs(1'b1);
    csAbsoluteOffset <= 4'h9;
    put(8'h00, 8'hfc); chk_cs(1'b0);
    put(8'h00, 8'h04); chk_cs(1'b1);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) put(8'h00, 8'hfc);
      @(posedge core_clk) syncMode <= 3'h4 + 3'(k % 4);
      repeat (3) @(posedge core_clk);
      #1 chk({7'h0, syncSearchEn}, {7'h0, k < 4});
    end
    syncMode <= 3'h0; csAbsoluteOffset <= 4'h0; csBaseThreshold <= 8'h7f;
    put(8'h00, 8'h00);
    chk({7'h0, syncSearchEn}, 8'h01);
    put(8'h00, 8'h30); chk_cs(1'b0);
    for (int s = 1; s < 4; s++) begin
      csRelativeStepSel <= 2'(s);
      st = (s == 1) ? 12 : (s == 2) ? 20 : 28;
      put(8'h00, 8'h00);
      put(8'h00, 8'(st - 1)); chk_cs(1'b0);
      put(8'h00, 8'h00);
      put(8'h00, 8'(st)); chk_cs(1'b1);
      put(8'h00, 8'h00); chk_cs(1'b0);
    end
    hostU.command(1'b0);
    wait_state(sscs_pkg::STATE_NUM_IDLE);
    syncMode <= 3'h2;
    gainCfg <= '{frontAmpGainCeiling: 3'h3, digitalGainCeiling: 2'h3, demodLevelTarget: 3'h3};
    hostU.command(1'b1);
    wait_state(sscs_pkg::STATE_NUM_RX);
    put(8'h10, 8'h20);
    @(posedge core_clk) syncDetect <= 1'b1;
    @(posedge core_clk) syncDetect <= 1'b0;
    put(8'h10, 8'h40); chk(strengthValue, 8'h30);
    chk({7'h0, packetStatusReg.syncFound}, 8'h01);
    chk(8'(hostU.raw_to_half_dbm(strengthValue)), 8'h9c);
    @(posedge core_clk) packetEnd <= 1'b1;
    @(posedge core_clk) packetEnd <= 1'b0;
    #1 chk({7'h0, statusByteValid}, 8'h01);
    chk(statusByte, 8'h30);
    @(posedge core_clk) #1 chk({7'h0, statusByteValid}, 8'h00);
    appendPacketStatusEn <= 1'b0;
    @(posedge core_clk) packetEnd <= 1'b1;
    @(posedge core_clk) packetEnd <= 1'b0;
    #1 chk({7'h0, statusByteValid}, 8'h00);
    hostU.command(1'b0);
    hostU.command(1'b1);
    wait_state(sscs_pkg::STATE_NUM_RX);
    put(8'h10, 8'h40); chk(strengthValue, 8'h50);
    @(posedge core_clk) rxOverflow <= 1'b1;
    @(posedge core_clk) rxOverflow <= 1'b0;
    wait_state(sscs_pkg::STATE_NUM_OVF);
    hostU.command(1'b0);
    wait_state(sscs_pkg::STATE_NUM_IDLE);
    end_sim();
  end
endmodule
